// ### sdev_consts.svh
`ifndef SDEV_CONSTS_SVH
`define SDEV_CONSTS_SVH

`define SDEV_ADDR_W 8
`define SDEV_OFF_EVENT_STATUS 8'h00
`define SDEV_OFF_LINE_STATUS 8'h04
`define SDEV_OFF_IRQ_MASK 8'h08
`define SDEV_OFF_BLOCK_LENGTH 8'h0c
`define SDEV_OFF_BLOCK_COUNT 8'h10
`define SDEV_OFF_REMAINING 8'h14
`define SDEV_OFF_CTRL 8'h18

`define SDEV_EV_W 12
`define SDEV_EV_DATA_DONE 0
`define SDEV_EV_BUSY_DONE 1
`define SDEV_EV_RESP_DONE 2
`define SDEV_EV_READ_TOUT 3
`define SDEV_EV_RESP_TOUT 4
`define SDEV_EV_WRITE_CRC 5
`define SDEV_EV_READ_CRC 6
`define SDEV_EV_RESP_CRC 7
`define SDEV_EV_TX_READY 8
`define SDEV_EV_RX_READY 9
`define SDEV_EV_LINE3_EDGE 10
`define SDEV_EV_XFER_DONE 11

`define SDEV_LS_BUSY 0
`define SDEV_LS_TX_EMPTY 1
`define SDEV_LS_RX_FULL 2
`define SDEV_LS_CLK_STOPPED 3
`define SDEV_LS_CARD_DATA_LINE3 4

`define SDEV_CTRL_WRITE_DIR 0
`define SDEV_CTRL_EDGE_LO 1
`define SDEV_CTRL_EDGE_HI 2
`define SDEV_CTRL_FIFO_LEV 3
`define SDEV_CTRL_RESP_EXP 4
`define SDEV_CTRL_BUSY_EXP 5
`define SDEV_CTRL_START 6
`define SDEV_CTRL_W 6

`define SDEV_BLEN_W 12
`define SDEV_BLEN_RESET 12'h200
`define SDEV_NBLK_W 16
`define SDEV_FIFO_W 8
`define SDEV_CHUNK_LO_BYTES 8'h10
`define SDEV_CHUNK_HI_BYTES 8'h20

`define SDEV_CLK_PERIOD_NS 50
`define SDEV_CLK_STOP_NS 3200
`define SDEV_CLK_STOP_CYC (`SDEV_CLK_STOP_NS / `SDEV_CLK_PERIOD_NS)
`define SDEV_STOP_CNT_W 7

`endif

// ### sdev_pkg.sv
package sdev_pkg;

  typedef enum logic [1:0] {
    SDEV_EDGE_OFF = 2'b00,
    SDEV_EDGE_RISE = 2'b01,
    SDEV_EDGE_FALL = 2'b10,
    SDEV_EDGE_BOTH = 2'b11
  } sdev_edge_t;

  typedef enum logic [2:0] {
    SDEV_XS_IDLE = 3'b000,
    SDEV_XS_MOVE = 3'b001,
    SDEV_XS_RD_CRC = 3'b010,
    SDEV_XS_WR_CRC = 3'b011,
    SDEV_XS_WR_PROG = 3'b100
  } sdev_xfer_t;

endpackage : sdev_pkg

// ### sdev_pin_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sdev_pin_if;
  logic [2:0] raw;
  logic card_data_line3_lvl;
  logic card_data_line3_rise;
  logic card_data_line3_fall;
  logic busy_lvl;
  logic clk_edge;
  modport sync (input raw, output card_data_line3_lvl, output card_data_line3_rise, output card_data_line3_fall,
                output busy_lvl, output clk_edge);
  modport core (output raw, input card_data_line3_lvl, input card_data_line3_rise, input card_data_line3_fall,
                input busy_lvl, input clk_edge);
endinterface : sdev_pin_if
`default_nettype wire

// ### sdev_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sdev_pin_sync
  import sdev_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  sdev_pin_if.sync pins
);
  // Bit 0 card data line 3, bit 1 card data line 0, bit 2 card clock
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;

  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_sync
      // First stage feeds only the second; edges come from stages two and three
      always_ff @(posedge pclk or negedge presetn) begin
        // Stages reset to the pin's idle level: card clock parks low, data lines idle high
        if (!presetn) begin
          s1_q[i] <= (i != 2);
          s2_q[i] <= (i != 2);
          s3_q[i] <= (i != 2);
        end else begin
          s1_q[i] <= pins.raw[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
        end
      end
    end
  endgenerate

  assign pins.card_data_line3_lvl = s2_q[0];
  assign pins.card_data_line3_rise = s2_q[0] & ~s3_q[0];
  assign pins.card_data_line3_fall = ~s2_q[0] & s3_q[0];
  // Card pulls data line 0 low while busy
  assign pins.busy_lvl = ~s2_q[1];
  assign pins.clk_edge = s2_q[2] ^ s3_q[2];

endmodule : sdev_pin_sync
`default_nettype wire

// ### sdev_event_status.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdev_consts.svh"
module sdev_event_status
  import sdev_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SDEV_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic card_clk_pin,
  input wire logic card_data_line3,
  input wire logic card_data_line0,
  input wire logic cmd_sent,
  input wire logic resp_received,
  input wire logic resp_crc_bad,
  input wire logic resp_timeout,
  input wire logic read_timeout,
  input wire logic busy_check,
  input wire logic rx_crc_done,
  input wire logic rx_crc_bad,
  input wire logic wr_crc_done,
  input wire logic wr_crc_bad,
  input wire logic tx_byte_to_shift,
  input wire logic rx_byte_in,
  input wire logic rx_data_rd,
  input wire logic [`SDEV_FIFO_W-1:0] fifo_level,
  input wire logic tx_shift_empty,
  input wire logic rx_shift_full,
  output logic irq,
  output logic dma_req
);

  sdev_pin_if pins ();

  sdev_pin_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pins(pins)
  );

  assign pins.raw = {card_clk_pin, card_data_line0, card_data_line3};

  // Register state
  logic [`SDEV_EV_W-1:0] ev_q;
  logic [`SDEV_EV_W-1:0] ev_d;
  logic [`SDEV_EV_W-1:0] mask_q;
  logic [`SDEV_BLEN_W-1:0] blen_q;
  logic [`SDEV_NBLK_W-1:0] nblk_q;
  logic [`SDEV_CTRL_W-1:0] ctrl_q;
  logic [`SDEV_NBLK_W-1:0] remain_q;
  logic [`SDEV_BLEN_W-1:0] byte_cnt_q;
  logic [`SDEV_FIFO_W-1:0] chunk_cnt_q;
  logic [`SDEV_STOP_CNT_W-1:0] stop_cnt_q;
  logic [`SDEV_EV_W-1:0] rd_snap_q;
  logic bw_wait_q;
  sdev_xfer_t xs_q;
  sdev_xfer_t xs_d;

  // APB decode
  wire setup = psel & ~penable;
  wire done = psel & penable & pready;
  wire wr_done = done & pwrite;
  wire rd_done = done & ~pwrite;
  wire hit_ev = paddr == `SDEV_OFF_EVENT_STATUS;
  wire hit_ls = paddr == `SDEV_OFF_LINE_STATUS;
  wire hit_mask = paddr == `SDEV_OFF_IRQ_MASK;
  wire hit_blen = paddr == `SDEV_OFF_BLOCK_LENGTH;
  wire hit_nblk = paddr == `SDEV_OFF_BLOCK_COUNT;
  wire hit_rem = paddr == `SDEV_OFF_REMAINING;
  wire hit_ctrl = paddr == `SDEV_OFF_CTRL;
  wire hit_any = hit_ev | hit_ls | hit_mask | hit_blen | hit_nblk | hit_rem | hit_ctrl;
  wire start = wr_done & hit_ctrl & pwdata[`SDEV_CTRL_START];
  wire ev_clear = rd_done & hit_ev;
  // Per-register write strobes
  wire wr_mask = wr_done & hit_mask;
  wire wr_blen = wr_done & hit_blen;
  wire wr_nblk = wr_done & hit_nblk;
  wire wr_ctrl = wr_done & hit_ctrl;

  // Control fields
  wire write_dir = ctrl_q[`SDEV_CTRL_WRITE_DIR];
  wire fifo_lev = ctrl_q[`SDEV_CTRL_FIFO_LEV];
  wire resp_exp = ctrl_q[`SDEV_CTRL_RESP_EXP];
  wire busy_exp = ctrl_q[`SDEV_CTRL_BUSY_EXP];
  sdev_edge_t edge_sel;
  assign edge_sel = sdev_edge_t'(ctrl_q[`SDEV_CTRL_EDGE_HI:`SDEV_CTRL_EDGE_LO]);

  // Line status; pin-derived bits lag their pins by the two synchroniser stages
  wire clk_stopped = stop_cnt_q == `SDEV_STOP_CNT_W'(`SDEV_CLK_STOP_CYC);
  wire [`SDEV_EV_W-1:0] ls_val;
  assign ls_val[`SDEV_LS_BUSY] = pins.busy_lvl;
  assign ls_val[`SDEV_LS_TX_EMPTY] = tx_shift_empty;
  assign ls_val[`SDEV_LS_RX_FULL] = rx_shift_full;
  assign ls_val[`SDEV_LS_CLK_STOPPED] = clk_stopped;
  assign ls_val[`SDEV_LS_CARD_DATA_LINE3] = pins.card_data_line3_lvl;
  assign ls_val[`SDEV_EV_W-1:`SDEV_LS_CARD_DATA_LINE3+1] = '0;

  // Read multiplexer; unmapped addresses read zero
  wire [31:0] rd_val =
    hit_ev ? {{(32-`SDEV_EV_W){1'b0}}, ev_q} :
    hit_ls ? {{(32-`SDEV_EV_W){1'b0}}, ls_val} :
    hit_mask ? {{(32-`SDEV_EV_W){1'b0}}, mask_q} :
    hit_blen ? {{(32-`SDEV_BLEN_W){1'b0}}, blen_q} :
    hit_nblk ? {{(32-`SDEV_NBLK_W){1'b0}}, nblk_q} :
    hit_rem ? {{(32-`SDEV_NBLK_W){1'b0}}, remain_q} :
    hit_ctrl ? {{(32-`SDEV_CTRL_W){1'b0}}, ctrl_q} :
    32'h0000_0000;

  // Transfer byte accounting
  wire byte_evt = write_dir ? tx_byte_to_shift : rx_byte_in;
  wire moving = xs_q == SDEV_XS_MOVE;
  wire blk_end = moving & byte_evt & (byte_cnt_q == blen_q - `SDEV_BLEN_W'(1));
  // A zero block count means an open-ended transfer that never self-terminates
  wire last_byte = blk_end & (nblk_q != '0) & (remain_q == `SDEV_NBLK_W'(1));

  // FIFO threshold and DMA chunking
  wire [`SDEV_FIFO_W-1:0] chunk = fifo_lev ? `SDEV_CHUNK_HI_BYTES : `SDEV_CHUNK_LO_BYTES;
  wire chunk_end = byte_evt & (chunk_cnt_q == chunk - `SDEV_FIFO_W'(1));
  wire rx_over = ~write_dir & (fifo_level > chunk);
  wire tx_under = write_dir & (fifo_level < chunk);

  // Line 3 edge selection
  wire line3_hit =
    ((edge_sel == SDEV_EDGE_RISE) | (edge_sel == SDEV_EDGE_BOTH)) & pins.card_data_line3_rise |
    ((edge_sel == SDEV_EDGE_FALL) | (edge_sel == SDEV_EDGE_BOTH)) & pins.card_data_line3_fall;

  // Busy-done: immediate if the card is idle at the check, else on busy release
  wire busy_done_now = busy_exp & busy_check & ~pins.busy_lvl;
  wire busy_done_late = bw_wait_q & ~pins.busy_lvl;

  // Transfer state machine
  always_comb begin
    xs_d = xs_q;
    unique case (xs_q)
      SDEV_XS_IDLE: begin
        if (start) begin
          xs_d = SDEV_XS_MOVE;
        end
      end
      SDEV_XS_MOVE: begin
        if (last_byte) begin
          xs_d = write_dir ? SDEV_XS_WR_CRC : SDEV_XS_RD_CRC;
        end
      end
      SDEV_XS_RD_CRC: begin
        if (rx_crc_done) begin
          xs_d = SDEV_XS_IDLE;
        end
      end
      SDEV_XS_WR_CRC: begin
        if (wr_crc_done) begin
          xs_d = wr_crc_bad ? SDEV_XS_IDLE : SDEV_XS_WR_PROG;
        end
      end
      SDEV_XS_WR_PROG: begin
        if (~pins.busy_lvl) begin
          xs_d = SDEV_XS_IDLE;
        end
      end
      default: begin
        xs_d = SDEV_XS_IDLE;
      end
    endcase
    if (start) begin
      xs_d = SDEV_XS_MOVE;
    end
  end

  wire rd_data_done = (xs_q == SDEV_XS_RD_CRC) & rx_crc_done & ~rx_crc_bad;
  wire wr_data_done = (xs_q == SDEV_XS_WR_PROG) & ~pins.busy_lvl;

  // Event sources
  wire [`SDEV_EV_W-1:0] ev_set;
  assign ev_set[`SDEV_EV_DATA_DONE] = rd_data_done | wr_data_done;
  assign ev_set[`SDEV_EV_BUSY_DONE] = busy_done_now | busy_done_late;
  assign ev_set[`SDEV_EV_RESP_DONE] = (resp_received & ~resp_crc_bad) |
                                      (cmd_sent & ~resp_exp);
  assign ev_set[`SDEV_EV_READ_TOUT] = read_timeout;
  assign ev_set[`SDEV_EV_RESP_TOUT] = resp_timeout;
  assign ev_set[`SDEV_EV_WRITE_CRC] = wr_crc_done & wr_crc_bad;
  assign ev_set[`SDEV_EV_READ_CRC] = rx_crc_done & rx_crc_bad;
  assign ev_set[`SDEV_EV_RESP_CRC] = resp_received & resp_crc_bad;
  assign ev_set[`SDEV_EV_TX_READY] = tx_under;
  assign ev_set[`SDEV_EV_RX_READY] = rx_over;
  assign ev_set[`SDEV_EV_LINE3_EDGE] = line3_hit;
  assign ev_set[`SDEV_EV_XFER_DONE] = last_byte;

  // Only the bits returned by the read are cleared, so an event arriving
  // between the sample and the completing edge survives
  wire [`SDEV_EV_W-1:0] ev_clr_mask = ev_clear ? rd_snap_q : '0;
  wire [`SDEV_EV_W-1:0] rx_rd_clr = rx_data_rd ? (`SDEV_EV_W'(1) << `SDEV_EV_RX_READY) : '0;
  genvar gi;
  generate
    for (gi = 0; gi < `SDEV_EV_W; gi = gi + 1) begin : g_flag
      // Set beats both clears so no event is lost
      assign ev_d[gi] = ev_set[gi] | (ev_q[gi] & ~ev_clr_mask[gi] & ~rx_rd_clr[gi]);
    end
  endgenerate

  // Each flag reaches the line only through its own mask bit
  wire irq_d = |(ev_d & mask_q);

  // Nothing here watches a debug halt, so breakpoints cannot stall it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_q <= '0;
      irq <= 1'b0;
    end else begin
      ev_q <= ev_d;
      irq <= irq_d;
    end
  end

  // APB slave: no wait state, data sampled in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~hit_any;
    end
  end

  // The snapshot tells the clear exactly which flags software has seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      rd_snap_q <= '0;
    end else if (setup & ~pwrite) begin
      prdata <= rd_val;
      rd_snap_q <= rd_val[`SDEV_EV_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= '0;
    end else if (wr_mask) begin
      mask_q <= pwdata[`SDEV_EV_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blen_q <= `SDEV_BLEN_RESET;
    end else if (wr_blen) begin
      blen_q <= pwdata[`SDEV_BLEN_W-1:0];
    end
  end

  // A zero count leaves the transfer open-ended until reset or a new start ends it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nblk_q <= '0;
    end else if (wr_nblk) begin
      nblk_q <= pwdata[`SDEV_NBLK_W-1:0];
    end
  end

  // Start is a strobe and is not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= '0;
    end else if (wr_ctrl) begin
      ctrl_q <= pwdata[`SDEV_CTRL_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xs_q <= SDEV_XS_IDLE;
    end else begin
      xs_q <= xs_d;
    end
  end

  // Block and byte counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_cnt_q <= '0;
      remain_q <= '0;
    end else begin
      if (start) begin
        byte_cnt_q <= '0;
        remain_q <= nblk_q;
      end else if (moving & byte_evt) begin
        if (blk_end) begin
          byte_cnt_q <= '0;
          if (remain_q != '0) begin
            remain_q <= remain_q - `SDEV_NBLK_W'(1);
          end
        end else begin
          byte_cnt_q <= byte_cnt_q + `SDEV_BLEN_W'(1);
        end
      end
    end
  end

  // DMA chunk counter, one-cycle request per chunk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chunk_cnt_q <= '0;
      dma_req <= 1'b0;
    end else begin
      dma_req <= chunk_end;
      if (start | chunk_end) begin
        chunk_cnt_q <= '0;
      end else if (byte_evt) begin
        chunk_cnt_q <= chunk_cnt_q + `SDEV_FIFO_W'(1);
      end
    end
  end

  // Busy wait arming
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bw_wait_q <= 1'b0;
    end else if (busy_exp & busy_check & pins.busy_lvl) begin
      bw_wait_q <= 1'b1;
    end else if (busy_done_late | ~busy_exp) begin
      bw_wait_q <= 1'b0;
    end
  end

  // Card clock stop detection; saturates so a long-idle clock reads stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_cnt_q <= '0;
    end else if (pins.clk_edge) begin
      stop_cnt_q <= '0;
    end else if (!clk_stopped) begin
      stop_cnt_q <= stop_cnt_q + `SDEV_STOP_CNT_W'(1);
    end
  end

endmodule : sdev_event_status
`default_nettype wire

// ### sdev_card_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdev_card_model (
  input wire logic clk_on,
  input wire logic busy,
  input wire logic d3,
  output logic card_clk_pin,
  output logic card_data_line3,
  output logic card_data_line0
);
  // Card clock parks low between frames, so the clock-stop status can be seen
  initial card_clk_pin = 1'b0;
  always #200 card_clk_pin = clk_on ? ~card_clk_pin : 1'b0;
  // Line 3 is driven from d3 at all times, so it never floats
  assign card_data_line3 = d3;
  // Card signals busy by pulling data line 0 low
  assign card_data_line0 = !busy;
endmodule : sdev_card_model
`default_nettype wire

// ### sdev_event_status_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdev_consts.svh"
module sdev_event_status_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SDEV_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic irq,
  input wire logic dma_req,
  input wire logic resp_received,
  input wire logic resp_crc_bad,
  input wire logic resp_timeout,
  input wire logic read_timeout,
  input wire logic busy_check,
  input wire logic rx_crc_done,
  input wire logic wr_crc_done,
  input wire logic wr_crc_bad,
  input wire logic card_data_line0,
  input wire logic card_data_line3
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [11:0] mask_q;
  logic [5:0] ctrl_q;
  wire wr_done = psel && penable && pready && pwrite;
  wire rd_st = psel && penable && pready && !pwrite && paddr == `SDEV_OFF_EVENT_STATUS;
  wire quiet = !(resp_received || resp_timeout || read_timeout || rx_crc_done || wr_crc_done);
  // Shadows of mask and control, so irq can be judged from the bus alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= '0;
      ctrl_q <= '0;
    end else if (wr_done) begin
      if (paddr == `SDEV_OFF_IRQ_MASK) mask_q <= pwdata[11:0];
      if (paddr == `SDEV_OFF_CTRL) ctrl_q <= pwdata[5:0];
    end
  end
  a_mask_gates_irq: assert property (mask_q == '0 && $past(mask_q) == '0 |-> !irq)
    else $error("irq high while all masked");
  a_resp_crc_irq: assert property (resp_received && resp_crc_bad && mask_q[7] && !wr_done |=> irq)
    else $error("response crc error gave no irq");
  a_read_tout_irq: assert property (read_timeout && mask_q[3] && !wr_done |=> irq)
    else $error("read timeout gave no irq");
  a_wr_crc_irq: assert property (wr_crc_done && wr_crc_bad && mask_q[5] && !wr_done |=> irq)
    else $error("write crc error gave no irq");
  a_set_wins_clear: assert property (rd_st && resp_timeout && mask_q[4] |=> irq)
    else $error("event lost in status clear");
  a_read_clears_all: assert property (rd_st && quiet && $past(quiet) && (mask_q & 12'hf07) == '0
    && mask_q == $past(mask_q) |=> !irq)
    else $error("status read left a flag set");
  a_dma_one_cycle: assert property (dma_req |=> !dma_req)
    else $error("dma request longer than one cycle");
  a_line3_rise: assert property ($rose(card_data_line3) && ctrl_q[2:1] == 2'b01 && mask_q[10]
    |-> ##[1:6] irq)
    else $error("line 3 edge gave no irq");
  a_busy_done_now: assert property (busy_check && ctrl_q[5] && mask_q[1] && card_data_line0
    && $past(card_data_line0, 2) |-> ##[1:2] irq)
    else $error("busy done missing when not busy");
  c_status_read: cover property (rd_st && irq);
  c_dma: cover property (dma_req);
  c_line3: cover property ($rose(card_data_line3) && mask_q[10]);
endmodule : sdev_event_status_assertions
bind sdev_event_status sdev_event_status_assertions u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .irq, .dma_req, .resp_received, .resp_crc_bad, .resp_timeout,
  .read_timeout, .busy_check, .rx_crc_done, .wr_crc_done, .wr_crc_bad, .card_data_line0,
  .card_data_line3);
`default_nettype wire

// ### sdev_event_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdev_consts.svh"
module sdev_event_status_tb;
  import sdev_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, dma_req, err, card_clk, line3, line0;
  logic clk_on = 1'b0, busy = 1'b0, d3 = 1'b1, txe = 1'b1, rxf = 1'b0;
  logic [12:0] pu = 13'h0;
  logic [7:0] lvl = 8'h10;
  int failures = 0, n_checks = 0, ndma = 0, n0;
  // Pulse vectors and the status bit each one must raise
  logic [12:0] ev [8] = '{13'h001, 13'h002, 13'h006, 13'h008, 13'h010, 13'h020, 13'h0c0, 13'h300};
  logic [11:0] eb [8] = '{12'h004, 12'h004, 12'h080, 12'h010, 12'h008, 12'h002, 12'h040, 12'h020};
  always #25 pclk = ~pclk;
  always @(posedge pclk) if (dma_req === 1'b1) ndma <= ndma + 1;
  sdev_card_model u_card (.clk_on(clk_on), .busy(busy), .d3(d3), .card_clk_pin(card_clk),
    .card_data_line3(line3), .card_data_line0(line0));
  sdev_event_status u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .card_clk_pin(card_clk), .card_data_line3(line3), .card_data_line0(line0),
    .cmd_sent(pu[0]), .resp_received(pu[1]), .resp_crc_bad(pu[2]), .resp_timeout(pu[3]),
    .read_timeout(pu[4]), .busy_check(pu[5]), .rx_crc_done(pu[6]), .rx_crc_bad(pu[7]),
    .wr_crc_done(pu[8]), .wr_crc_bad(pu[9]), .tx_byte_to_shift(pu[10]), .rx_byte_in(pu[11]),
    .rx_data_rd(pu[12]), .fifo_level(lvl), .tx_shift_empty(txe), .rx_shift_full(rxf), .irq,
    .dma_req);
  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk32
  task automatic chk1(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1
  // Bus cycle; the slave's wait is bounded so a dead pready ends the run
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1) begin
      failures++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk32(nm, e, rd);
  endtask : rchk
  task automatic pulse(input logic [12:0] v);
    @(posedge pclk);
    pu <= v;
    @(posedge pclk);
    pu <= 13'h0;
  endtask : pulse
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (70) @(posedge pclk);
    rchk(8'h0c, 32'h200, "block length");
    rchk(8'h14, 32'h0, "remaining");
    rchk(8'h04, 32'h1a, "line status");
    txe <= 1'b0;
    rxf <= 1'b1;
    clk_on <= 1'b1;
    repeat (20) @(posedge pclk);
    rchk(8'h04, 32'h14, "line status");
    apb(1'b0, 8'h1c, 32'h0);
    chk1("slverr", 1'b1, err);
    clk_on <= 1'b0;
    $display("test status bits done");
    apb(1'b1, 8'h18, 32'h20);
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, 8'h08, i[0] ? 32'h0 : {20'h0, eb[i / 2]});
      pulse(ev[i / 2]);
      repeat (2) @(posedge pclk);
      chk1("irq", !i[0], irq);
      rchk(8'h00, {20'h0, eb[i / 2]}, "event status");
      rchk(8'h00, 32'h0, "event status");
    end
    $display("test event flags done");
    apb(1'b1, 8'h08, 32'h10);
    pulse(13'h008);
    fork
      rchk(8'h00, 32'h10, "event status");
      begin
        repeat (2) @(posedge pclk);
        pu <= 13'h008;
        @(posedge pclk);
        pu <= 13'h0;
      end
    join
    rchk(8'h00, 32'h10, "event status");
    rchk(8'h00, 32'h0, "event status");
    $display("test clear race done");
    apb(1'b1, 8'h0c, 32'h10);
    apb(1'b1, 8'h10, 32'h2);
    apb(1'b1, 8'h08, 32'h801);
    n0 = ndma;
    apb(1'b1, 8'h18, 32'h41);
    for (int i = 1; i < 32; i++) begin
      pulse(13'h400);
      if (i == 16) rchk(8'h14, 32'h1, "remaining");
    end
    repeat (3) @(posedge pclk);
    chk1("irq", 1'b0, irq);
    pulse(13'h400);
    repeat (3) @(posedge pclk);
    chk1("irq", 1'b1, irq);
    chk32("dma count", 32'h2, ndma - n0);
    pulse(13'h001);
    rchk(8'h00, 32'h804, "event status");
    busy <= 1'b1;
    pulse(13'h100);
    repeat (10) @(posedge pclk);
    rchk(8'h04, 32'h1d, "line status");
    rchk(8'h00, 32'h0, "event status");
    busy <= 1'b0;
    repeat (10) @(posedge pclk);
    rchk(8'h00, 32'h1, "event status");
    $display("test write transfer done");
    apb(1'b1, 8'h0c, 32'h20);
    apb(1'b1, 8'h10, 32'h1);
    n0 = ndma;
    apb(1'b1, 8'h18, 32'h48);
    repeat (32) pulse(13'h800);
    repeat (3) @(posedge pclk);
    chk1("irq", 1'b1, irq);
    chk32("dma count", 32'h1, ndma - n0);
    rchk(8'h00, 32'h800, "event status");
    pulse(13'h040);
    repeat (2) @(posedge pclk);
    rchk(8'h00, 32'h1, "event status");
    $display("test read transfer done");
    apb(1'b1, 8'h18, 32'h0);
    apb(1'b1, 8'h08, 32'h200);
    lvl <= 8'h11;
    repeat (4) @(posedge pclk);
    chk1("irq", 1'b1, irq);
    lvl <= 8'h10;
    pulse(13'h1000);
    repeat (2) @(posedge pclk);
    chk1("irq", 1'b0, irq);
    apb(1'b1, 8'h08, 32'h100);
    apb(1'b1, 8'h18, 32'h1);
    lvl <= 8'h0f;
    repeat (4) @(posedge pclk);
    chk1("irq", 1'b1, irq);
    lvl <= 8'h10;
    rchk(8'h00, 32'h100, "event status");
    $display("test fifo ready done");
    apb(1'b1, 8'h08, 32'h400);
    apb(1'b1, 8'h18, 32'h2);
    d3 <= 1'b0;
    repeat (8) @(posedge pclk);
    chk1("irq", 1'b0, irq);
    d3 <= 1'b1;
    repeat (8) @(posedge pclk);
    chk1("irq", 1'b1, irq);
    rchk(8'h00, 32'h400, "event status");
    apb(1'b1, 8'h18, 32'h4);
    d3 <= 1'b0;
    repeat (8) @(posedge pclk);
    chk1("irq", 1'b1, irq);
    rchk(8'h00, 32'h400, "event status");
    apb(1'b1, 8'h18, 32'h6);
    d3 <= 1'b1;
    repeat (8) @(posedge pclk);
    chk1("irq", 1'b1, irq);
    $display("test line3 edge done");
    apb(1'b1, 8'h08, 32'h4);
    apb(1'b1, 8'h18, 32'h10);
    pulse(13'h001);
    repeat (2) @(posedge pclk);
    chk1("irq", 1'b0, irq);
    $display("test response expected done");
    summarize();
  end
endmodule : sdev_event_status_tb
`default_nettype wire
